// *** rtl/ssm_pkg.sv ***
// Constants and types shared by the safety signal mapper
package ssm_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] MIN_PULSE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] BUS_WORD_OFFSET = 8'h0c;

    // Control register fields
    localparam int CTRL_CFG_LSB = 0;
    localparam int CTRL_CFG_MSB = 1;

    // Status register fields
    localparam int STATUS_ERR_BIT = 0;
    localparam int STATUS_LOCK_BIT = 1;
    localparam int STATUS_MODE_BIT = 2;
    localparam int STATUS_ENABLE_BIT = 3;
    localparam int STATUS_STOP_BIT = 4;
    localparam int STATUS_BRAKE_BIT = 5;
    localparam int STATUS_HOME_BIT = 6;
    localparam int STATUS_SEL_LSB = 8;
    localparam int STATUS_SEL_MSB = 15;

    // Safety bus control word bit positions
    localparam int BUS_MODE_BIT = 0;
    localparam int BUS_STOP_BIT = 1;
    localparam int BUS_ENABLE_BIT = 2;
    localparam int BUS_CODE_LSB = 3;
    localparam int BUS_CODE_MSB = 5;
    localparam int BUS_BRAKE_BIT = 6;

    // Safe cam status bit positions
    localparam int CAM_LOAD_BIT = 0;
    localparam int CAM_EQUIP_BIT = 1;

    // Active configuration, Gray coded
    typedef enum logic [1:0] {
        SSM_CFG_A = 2'b00,
        SSM_CFG_B = 2'b01,
        SSM_CFG_C = 2'b11
    } ssm_cfg_t;

    // Values after reset
    localparam logic [1:0] CTRL_RESET = 2'b00;
    localparam logic [31:0] MIN_PULSE_RESET = 32'h0000_0019;

    // Start pulse longest duration and its cycle count
    localparam longint CLK_HZ = 25_000_000;
    localparam longint MAX_PULSE_S = 30;
    localparam longint MAX_PULSE_CYCLES = MAX_PULSE_S * CLK_HZ;
    localparam int PULSE_CNT_W = 30;
endpackage : ssm_pkg

// *** rtl/ssm_mapper.sv ***
// Safety signal mapper: routes safe inputs and bus control bits to drive commands
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module ssm_mapper #(
    parameter int unsigned MAX_PULSE_CYCLES = 32'(ssm_pkg::MAX_PULSE_CYCLES)
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Safe and functional inputs from pins
    input wire logic mode_selector,
    input wire logic mode_switch,
    input wire logic stop_in_n,
    input wire logic restart_enable,
    input wire logic loading_selector,
    input wire logic equipping_selector,
    input wire logic [1:0] safe_cam_bits,
    input wire logic home_switch,
    input wire logic [7:0] bus_control_word,
    // Drive state machine commands
    output logic mode_selection_signal,
    output logic enabling_control_signal,
    output logic emergency_stop_signal_n,
    output logic [7:0] special_mode_select,
    output logic brake_release,
    output logic homing_reference,
    output logic input_error
);
    // Two-flop synchronisers for every pin input
    localparam int PIN_W = 17;
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;

    assign pins = {bus_control_word, home_switch, safe_cam_bits, equipping_selector,
                   loading_selector, restart_enable, stop_in_n, mode_switch, mode_selector};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Synchronised input names
    logic s_mode;
    logic s_switch;
    logic s_stop_n;
    logic s_start;
    logic s_load;
    logic s_equip;
    logic [1:0] s_cam;
    logic s_home;
    logic [7:0] s_bus;

    assign s_mode = pin_sync_reg[0];
    assign s_switch = pin_sync_reg[1];
    assign s_stop_n = pin_sync_reg[2];
    assign s_start = pin_sync_reg[3];
    assign s_load = pin_sync_reg[4];
    assign s_equip = pin_sync_reg[5];
    assign s_cam = pin_sync_reg[7:6];
    assign s_home = pin_sync_reg[8];
    assign s_bus = pin_sync_reg[16:9];

    // Software-visible state
    ssm_pkg::ssm_cfg_t cfg_reg;
    logic [31:0] min_pulse_reg;
    logic err_reg;
    logic lock_reg;

    // APB handshake: one wait state, access completes when pready is high
    logic apb_access;
    logic apb_done;
    logic pready_next;
    logic addr_ok;
    logic [31:0] rdata_next;

    assign apb_access = psel & penable;
    assign apb_done = apb_access & pready;
    assign pready_next = apb_access & ~pready;

    // Address decode and read mux
    always_comb
    begin
        addr_ok = 1'b1;
        rdata_next = 32'h0000_0000;
        if (paddr == ssm_pkg::CTRL_OFFSET)
        begin
            rdata_next[ssm_pkg::CTRL_CFG_MSB:ssm_pkg::CTRL_CFG_LSB] = cfg_reg;
        end
        else if (paddr == ssm_pkg::MIN_PULSE_OFFSET)
        begin
            rdata_next = min_pulse_reg;
        end
        else if (paddr == ssm_pkg::STATUS_OFFSET)
        begin
            rdata_next[ssm_pkg::STATUS_ERR_BIT] = err_reg;
            rdata_next[ssm_pkg::STATUS_LOCK_BIT] = lock_reg;
            rdata_next[ssm_pkg::STATUS_MODE_BIT] = mode_selection_signal;
            rdata_next[ssm_pkg::STATUS_ENABLE_BIT] = enabling_control_signal;
            rdata_next[ssm_pkg::STATUS_STOP_BIT] = emergency_stop_signal_n;
            rdata_next[ssm_pkg::STATUS_BRAKE_BIT] = brake_release;
            rdata_next[ssm_pkg::STATUS_HOME_BIT] = homing_reference;
            rdata_next[ssm_pkg::STATUS_SEL_MSB:ssm_pkg::STATUS_SEL_LSB] = special_mode_select;
        end
        else if (paddr == ssm_pkg::BUS_WORD_OFFSET)
        begin
            rdata_next[7:0] = s_bus;
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // APB answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= pready_next;
            prdata <= (pready_next && !pwrite) ? rdata_next : 32'h0000_0000;
            pslverr <= pready_next & ~addr_ok;
        end
    end

    // Configuration select, written only with a valid code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= ssm_pkg::ssm_cfg_t'(ssm_pkg::CTRL_RESET);
        end
        else if (apb_done && pwrite && paddr == ssm_pkg::CTRL_OFFSET)
        begin
            if (pwdata[1:0] == ssm_pkg::SSM_CFG_A || pwdata[1:0] == ssm_pkg::SSM_CFG_B ||
                pwdata[1:0] == ssm_pkg::SSM_CFG_C)
            begin
                cfg_reg <= ssm_pkg::ssm_cfg_t'(pwdata[1:0]);
            end
        end
    end

    // Minimum start pulse duration in clock cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            min_pulse_reg <= ssm_pkg::MIN_PULSE_RESET;
        end
        else if (apb_done && pwrite && paddr == ssm_pkg::MIN_PULSE_OFFSET)
        begin
            min_pulse_reg <= pwdata;
        end
    end

    // Start input edge and pulse length tracking
    logic start_prev_reg;
    logic start_fall;
    logic [ssm_pkg::PULSE_CNT_W-1:0] pulse_cnt_reg;
    localparam logic [ssm_pkg::PULSE_CNT_W-1:0] PULSE_LIMIT =
        ssm_pkg::PULSE_CNT_W'(MAX_PULSE_CYCLES);

    assign start_fall = start_prev_reg & ~s_start;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_prev_reg <= 1'b0;
            pulse_cnt_reg <= '0;
        end
        else
        begin
            start_prev_reg <= s_start;
            if (!s_start)
            begin
                pulse_cnt_reg <= '0;
            end
            else if (pulse_cnt_reg != PULSE_LIMIT)
            begin
                pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
            end
        end
    end

    // Input error on short or overlong start pulse; set wins over write-1 clear
    logic err_short;
    logic err_long;
    logic err_set;
    logic err_clr;

    assign err_short = start_fall && (32'(pulse_cnt_reg) < min_pulse_reg);
    assign err_long = s_start && (pulse_cnt_reg == PULSE_LIMIT - 1'b1);
    assign err_set = err_short | err_long;
    assign err_clr = apb_done && pwrite && paddr == ssm_pkg::STATUS_OFFSET &&
                     pwdata[ssm_pkg::STATUS_ERR_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_reg <= 1'b0;
        end
        else if (err_set)
        begin
            err_reg <= 1'b1;
        end
        else if (err_clr)
        begin
            err_reg <= 1'b0;
        end
    end

    // Restart lockout fed by local stop AND bus stop bit
    logic and_result;

    assign and_result = s_stop_n & s_bus[ssm_pkg::BUS_STOP_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_reg <= 1'b0;
        end
        else if (!and_result)
        begin
            lock_reg <= 1'b0;
        end
        else if (start_fall)
        begin
            lock_reg <= 1'b1;
        end
    end

    // Binary-to-bit decoder, one select per code value
    logic [2:0] mode_code;
    logic [7:0] decoded;

    assign mode_code = s_bus[ssm_pkg::BUS_CODE_MSB:ssm_pkg::BUS_CODE_LSB];

    for (genvar i = 0; i < 8; i++)
    begin : g_decode
        assign decoded[i] = (mode_code == 3'(i));
    end

    // Output next values per configuration
    logic mode_next;
    logic enable_next;
    logic stop_next;
    logic [7:0] sel_next;
    logic brake_next;
    logic home_next;

    always_comb
    begin
        mode_next = s_mode;
        enable_next = ~s_mode;
        stop_next = s_stop_n;
        sel_next = 8'h00;
        brake_next = 1'b0;
        home_next = 1'b0;
        case (cfg_reg)
            ssm_pkg::SSM_CFG_A:
            begin
                sel_next[0] = s_switch;
                sel_next[1] = ~s_switch;
            end
            ssm_pkg::SSM_CFG_B:
            begin
                mode_next = s_bus[ssm_pkg::BUS_MODE_BIT];
                enable_next = s_bus[ssm_pkg::BUS_ENABLE_BIT];
                stop_next = lock_reg & and_result;
                sel_next = decoded;
                brake_next = s_bus[ssm_pkg::BUS_BRAKE_BIT];
            end
            ssm_pkg::SSM_CFG_C:
            begin
                sel_next[0] = s_load & s_cam[ssm_pkg::CAM_LOAD_BIT];
                sel_next[1] = s_equip & s_cam[ssm_pkg::CAM_EQUIP_BIT];
                home_next = s_home;
            end
            default:
            begin
                sel_next = 8'h00;
            end
        endcase
    end

    // Registered outputs with safe reset state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_selection_signal <= 1'b0;
            enabling_control_signal <= 1'b0;
            emergency_stop_signal_n <= 1'b0;
            special_mode_select <= 8'h00;
            brake_release <= 1'b0;
            homing_reference <= 1'b0;
            input_error <= 1'b0;
        end
        else
        begin
            mode_selection_signal <= mode_next;
            enabling_control_signal <= enable_next;
            emergency_stop_signal_n <= stop_next;
            special_mode_select <= sel_next;
            brake_release <= brake_next;
            homing_reference <= home_next;
            input_error <= err_set | (err_reg & ~err_clr);
        end
    end

    // Checks on the mapping network
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_follow_ac;
        presetn && cfg_reg != ssm_pkg::SSM_CFG_B |=> mode_selection_signal == $past(s_mode) &&
            enabling_control_signal == !$past(s_mode);
    endproperty

    mode_follow_a: assert property (p_follow_ac)
        else $error("Mode or enabling output does not track the selector");

    // Reset-cycle outputs are zeroed, so the pass-through checks start after release
    switch_sel_a: assert property (
        presetn && cfg_reg == ssm_pkg::SSM_CFG_A ##1 cfg_reg == ssm_pkg::SSM_CFG_A
        |-> special_mode_select == {6'h00, !$past(s_switch), $past(s_switch)})
        else $error("Configuration A selects do not follow the switch");

    stop_pass_a: assert property (
        presetn && cfg_reg != ssm_pkg::SSM_CFG_B
        |=> emergency_stop_signal_n == $past(s_stop_n))
        else $error("Stop output does not pass the safe stop input");

    bus_cmd_a: assert property (
        cfg_reg == ssm_pkg::SSM_CFG_B |=>
        mode_selection_signal == $past(s_bus[0]) && enabling_control_signal == $past(s_bus[2])
        && brake_release == $past(s_bus[6]))
        else $error("Bus command bits not routed");

    decode_onehot_a: assert property (
        cfg_reg == ssm_pkg::SSM_CFG_B ##1
        cfg_reg == ssm_pkg::SSM_CFG_B |-> $onehot(special_mode_select) &&
        special_mode_select[$past(mode_code)])
        else $error("Decoder output not one-hot for the code");

    // A start edge may legally release the lockout again one cycle later
    stop_lock_a: assert property (
        cfg_reg == ssm_pkg::SSM_CFG_B && !and_result
        |=> !emergency_stop_signal_n && !lock_reg)
        else $error("Stop released while the AND result is low");

    restart_edge_a: assert property (
        !lock_reg && and_result && !start_fall
        |=> !lock_reg)
        else $error("Lockout released without a start falling edge");

    cam_gate_a: assert property (
        cfg_reg == ssm_pkg::SSM_CFG_C |=>
        special_mode_select[0] == ($past(s_load) && $past(s_cam[0])) &&
        special_mode_select[1] == ($past(s_equip) && $past(s_cam[1])) &&
        homing_reference == $past(s_home))
        else $error("Configuration C selects or homing wrong");

    // A clear in the following cycle is legal, so only the first cycle is checked
    short_pulse_a: assert property (
        err_short |=> err_reg && input_error)
        else $error("Short start pulse did not raise the input error");

    cover_cfg_b_release: cover property (cfg_reg == ssm_pkg::SSM_CFG_B && $rose(lock_reg));
    cover_short_err: cover property ($rose(err_reg));
    cover_cfg_c_sel: cover property (cfg_reg == ssm_pkg::SSM_CFG_C && special_mode_select[1]);
    cover_err_clear: cover property (err_reg ##1 !err_reg);
endmodule : ssm_mapper

// *** verification/ssm_far_side.sv ***
// Far-side model: safe input pairs, functional inputs and safety bus master
`timescale 1ns/1ns
module ssm_far_side (
    // Clock
    input wire logic pclk,
    // Levels commanded by the bench
    input wire logic [16:0] cmd,
    // Pins toward the mapper
    output logic mode_selector,
    output logic mode_switch,
    output logic stop_in_n,
    output logic restart_enable,
    output logic loading_selector,
    output logic equipping_selector,
    output logic [1:0] safe_cam_bits,
    output logic home_switch,
    output logic [7:0] bus_control_word
);
    logic [16:0] held = 17'h00000;

    // Levels move only just after a rising edge, as a real bus cycle would
    always @(posedge pclk)
    begin
        held <= cmd;
    end

    // Fan the held word out to the pins
    assign {bus_control_word, home_switch, safe_cam_bits, equipping_selector,
        loading_selector, restart_enable, stop_in_n, mode_switch, mode_selector} = held;
endmodule : ssm_far_side

// *** verification/testbench.sv ***
// Self-checking bench for the safety signal mapper
`timescale 1ns/1ns
module testbench;
    // Clock, reset and APB
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Pins and commands
    logic [16:0] cmd = 17'h00000;
    logic mode_selector, mode_switch, stop_in_n, restart_enable, loading_selector;
    logic equipping_selector, home_switch;
    logic [1:0] safe_cam_bits;
    logic [7:0] bus_control_word;
    logic mode_selection_signal, enabling_control_signal, emergency_stop_signal_n;
    logic [7:0] special_mode_select;
    logic brake_release, homing_reference, input_error;
    // Bench state
    logic [12:0] outv;
    logic [31:0] rd;
    logic err;
    logic [7:0] bw;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    // All drive commands except input_error as one vector
    assign outv = {mode_selection_signal, enabling_control_signal, emergency_stop_signal_n,
        special_mode_select, brake_release, homing_reference};

    ssm_mapper #(.MAX_PULSE_CYCLES(64)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_selector, .mode_switch,
        .stop_in_n, .restart_enable, .loading_selector, .equipping_selector, .safe_cam_bits,
        .home_switch, .bus_control_word, .mode_selection_signal, .enabling_control_signal,
        .emergency_stop_signal_n, .special_mode_select, .brake_release, .homing_reference,
        .input_error);

    ssm_far_side u_far (.pclk, .cmd, .mode_selector, .mode_switch, .stop_in_n,
        .restart_enable, .loading_selector, .equipping_selector, .safe_cam_bits,
        .home_switch, .bus_control_word);

    // Clock generator
    initial
    begin
        forever #20 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Compare a word
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Compare a single flag
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk_bit("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Apply pin levels and let them pass model, synchronisers and output stage
    task automatic pins(input logic [16:0] v);
        cmd <= v;
        repeat (5) @(posedge pclk);
    endtask : pins

    // Hold the restart input high for len cycles, then let the lockout settle
    task automatic pulse(input int len);
        cmd[3] <= 1'b1;
        repeat (len) @(posedge pclk);
        cmd[3] <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : pulse

    // Clear the sticky error over the bus
    task automatic clear_err();
        apb(1'b1, ssm_pkg::STATUS_OFFSET, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk_bit("error cleared", 1'b0, input_error);
    endtask : clear_err

    // Hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("ERROR timeout expected finish seen hang");
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        check("reset outputs", 32'h0, {18'h0, pready, outv});
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ssm_pkg::CTRL_OFFSET, 32'h0);
        check("ctrl reset", {30'h0, ssm_pkg::CTRL_RESET}, rd);
        chk_bit("mapped error", 1'b0, err);
        apb(1'b0, ssm_pkg::MIN_PULSE_OFFSET, 32'h0);
        check("min pulse reset", ssm_pkg::MIN_PULSE_RESET, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped data", 32'h0, rd);
        chk_bit("unmapped error", 1'b1, err);
        $display("test reset done");
        // Configuration A: selector, switch and stop wiring
        for (int i = 0; i < 8; i++)
        begin
            pins({14'h0, i[2], i[1], i[0]});
            check("cfg a", {19'h0, i[0], ~i[0], i[2], 6'h0, ~i[1], i[1], 2'b00},
                {19'h0, outv});
        end
        $display("test config a done");
        // Configuration B: bus word mapping and decoder, stop held active
        apb(1'b1, ssm_pkg::CTRL_OFFSET, 32'h00000001);
        for (int c = 0; c < 8; c++)
        begin
            bw = {1'b0, c[0], c[2:0], c[1], 1'b1, c[2]};
            pins({bw, 1'b1, 8'h00});
            check("cfg b", {19'h0, bw[0], bw[2], 1'b0, 8'h01 << c, bw[6], 1'b0},
                {19'h0, outv});
        end
        apb(1'b0, ssm_pkg::BUS_WORD_OFFSET, 32'h0);
        check("bus word", {24'h0, bw}, rd);
        $display("test config b done");
        // Restart lockout
        pins({8'h02, 5'h0, 1'b0, 1'b1, 2'b00});
        chk_bit("locked after reset", 1'b0, emergency_stop_signal_n);
        pulse(30);
        chk_bit("released", 1'b1, emergency_stop_signal_n);
        apb(1'b0, ssm_pkg::STATUS_OFFSET, 32'h0);
        check("status lock and stop", 32'h00000012, rd & 32'h00000012);
        pins({8'h00, 5'h0, 1'b0, 1'b1, 2'b00});
        chk_bit("bus stop", 1'b0, emergency_stop_signal_n);
        pins({8'h02, 5'h0, 1'b0, 1'b1, 2'b00});
        chk_bit("stays locked", 1'b0, emergency_stop_signal_n);
        pulse(30);
        chk_bit("released again", 1'b1, emergency_stop_signal_n);
        pins({8'h02, 5'h0, 1'b0, 1'b0, 2'b00});
        chk_bit("local stop", 1'b0, emergency_stop_signal_n);
        pins({8'h02, 5'h0, 1'b0, 1'b1, 2'b00});
        chk_bit("relocked", 1'b0, emergency_stop_signal_n);
        chk_bit("no error", 1'b0, input_error);
        $display("test restart done");
        // Pulse duration monitor, with the AND held false
        pins({8'h02, 5'h0, 1'b0, 1'b0, 2'b00});
        pulse(int'(ssm_pkg::MIN_PULSE_RESET) - 1);
        chk_bit("short pulse", 1'b1, input_error);
        apb(1'b0, ssm_pkg::STATUS_OFFSET, 32'h0);
        chk_bit("status error", 1'b1, rd[0]);
        clear_err();
        pulse(int'(ssm_pkg::MIN_PULSE_RESET));
        chk_bit("minimum pulse", 1'b0, input_error);
        pulse(80);
        chk_bit("long pulse", 1'b1, input_error);
        clear_err();
        // A programmed minimum replaces the reset value
        apb(1'b1, ssm_pkg::MIN_PULSE_OFFSET, 32'h0000000a);
        apb(1'b0, ssm_pkg::MIN_PULSE_OFFSET, 32'h0);
        check("min pulse written", 32'h0000000a, rd);
        pulse(10);
        chk_bit("new minimum", 1'b0, input_error);
        pulse(9);
        chk_bit("below new minimum", 1'b1, input_error);
        clear_err();
        $display("test pulse monitor done");
        // Configuration C: cam-gated selects and homing copy
        apb(1'b1, ssm_pkg::CTRL_OFFSET, 32'h00000003);
        apb(1'b1, ssm_pkg::CTRL_OFFSET, 32'h00000002);
        apb(1'b0, ssm_pkg::CTRL_OFFSET, 32'h0);
        check("ctrl code kept", 32'h00000003, rd);
        for (int i = 0; i < 16; i++)
        begin
            pins({8'h00, i[3], i[3:2], i[1], i[0], 1'b0, i[2], 1'b0, i[1]});
            check("cfg c", {19'h0, i[1], ~i[1], i[2], 6'h0, i[1] & i[3], i[0] & i[2],
                1'b0, i[3]}, {19'h0, outv});
        end
        $display("test config c done");
        complete_run();
    end
endmodule : testbench
